// ==== bench/mdf_properties.sv ====
/*
 Line checker for the control-to-device link.
 Assumes both ends keep the baud register at 0, one sample tick per clock.
*/
`timescale 1ns/10ps
module mdf_properties (
	input wire logic clk,
	input wire logic rst,
	input wire logic m2s_line,
	input wire logic s2m_line
);
	// ----------------------------------------------------------------
	// Low run counters
	// ----------------------------------------------------------------
	logic [7:0] m_low_reg;
	logic [7:0] m_low_next;
	logic [7:0] s_low_reg;
	logic [7:0] s_low_next;
	always_comb begin
		m_low_next = m2s_line ? 8'h00 : m_low_reg + 8'h01;
		s_low_next = s2m_line ? 8'h00 : s_low_reg + 8'h01;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			m_low_reg <= 8'h00;
			s_low_reg <= 8'h00;
		end else begin
			m_low_reg <= m_low_next;
			s_low_reg <= s_low_next;
		end
	end
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_idle_reset: assert property (disable iff (1'b0)
		rst ##1 1'b1 |-> m2s_line && s2m_line)
		else $error("line not idle high in reset");
	a_m_low_min: assert property ($fell(m2s_line) |-> !m2s_line [*8])
		else $error("control line low run too short");
	a_s_low_min: assert property ($fell(s2m_line) |-> !s2m_line [*8])
		else $error("device line low run too short");
	a_m_high_min: assert property ($rose(m2s_line) |-> m2s_line [*8])
		else $error("control line high run too short");
	a_s_high_min: assert property ($rose(s2m_line) |-> s2m_line [*8])
		else $error("device line high run too short");
	a_m_low_step: assert property ($rose(m2s_line) |-> m_low_reg[2:0] == 3'h0)
		else $error("control low run not whole bits");
	a_s_low_step: assert property ($rose(s2m_line) |-> s_low_reg[2:0] == 3'h0)
		else $error("device low run not whole bits");
	a_low_run_max: assert property (m_low_reg <= 8'hb0 && s_low_reg <= 8'hb0)
		else $error("low run longer than a frame");
	c_normal_bit: cover property ($rose(m2s_line) && m_low_reg == 8'h10);
	c_double_bit: cover property ($rose(m2s_line) && m_low_reg == 8'h08);
	c_reply: cover property ($fell(s2m_line));
endmodule

// ==== bench/uart_multidrop_address_filter_bench.sv ====
/*
 Bench joining one control end and one device end over the link.
 Assumes 200 MHz clock, baud register left at 0 on both ends.
*/
`timescale 1ns/10ps
module uart_multidrop_address_filter_bench;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic       c_wr = 1'b0;
	logic       c_rd = 1'b0;
	logic       d_wr = 1'b0;
	logic       d_rd = 1'b0;
	logic [7:0] c_rdata;
	logic [7:0] d_rdata;
	logic [6:0] cfg = 7'h07;
	logic [1:0] dst = 2'h0;
	logic [1:0] cst = 2'h0;
	logic [7:0] v;
	int         miscompares = 0;
	int         compares = 0;
	int         cycles = 0;
	mdf_link_if link ();
	mdf_control u_mdf_control (.clk(clk), .rst(rst), .link(link.ctrl),
		.addr(addr), .wdata(wdata), .wr(c_wr), .rd(c_rd), .rdata(c_rdata));
	mdf_device u_mdf_device (.clk(clk), .rst(rst), .link(link.dev),
		.addr(addr), .wdata(wdata), .wr(d_wr), .rd(d_rd), .rdata(d_rdata));
	mdf_properties u_mdf_properties (.clk(clk), .rst(rst),
		.m2s_line(link.m2s_line), .s2m_line(link.s2m_line));
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			miscompares++;
			end_of_test();
		end
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input bit dv, input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		if (dv) d_wr <= 1'b1;
		else c_wr <= 1'b1;
		@(posedge clk);
		d_wr <= 1'b0;
		c_wr <= 1'b0;
	endtask
	task automatic rd(input bit dv, input logic [1:0] a, output logic [7:0] q);
		@(posedge clk);
		addr <= a;
		if (dv) d_rd <= 1'b1;
		else c_rd <= 1'b1;
		@(posedge clk);
		d_rd <= 1'b0;
		c_rd <= 1'b0;
		// Read data stand only in the cycle after the strobe.
		@(posedge clk);
		q = dv ? d_rdata : c_rdata;
	endtask
	// Sends one character and waits for the sender's transmit complete.
	task automatic send(input bit dv, input logic mark, input logic [7:0] b);
		logic [7:0] q;
		q = 8'h00;
		wr(dv, mdf_pkg::OFS_CTRL, {mark, cfg});
		wr(dv, mdf_pkg::OFS_DATA, b);
		for (int n = 0; n < 400 && q[6] !== 1'b1; n++)
			rd(dv, mdf_pkg::OFS_STATUS, q);
		chk(q & 8'h40, 8'h40);
		wr(dv, mdf_pkg::OFS_STATUS, {6'h10, dv ? dst : cst});
	endtask
	task automatic rx(input bit dv, input logic acc, input logic mark,
		input logic [7:0] b);
		logic [7:0] q;
		rd(dv, mdf_pkg::OFS_STATUS, q);
		chk(q & 8'h9c, {acc, 7'h00});
		if (acc) begin
			if (cfg[2:0] == mdf_pkg::CS_9BIT) begin
				rd(dv, mdf_pkg::OFS_CTRL, q);
				chk(q & 8'h40, {1'b0, mark, 6'h00});
			end
			rd(dv, mdf_pkg::OFS_DATA, q);
			chk(q, b);
		end
	endtask
	task automatic set_st(input logic [1:0] d, input logic [1:0] c);
		dst = d;
		cst = c;
		wr(1'b1, mdf_pkg::OFS_STATUS, {6'h00, d});
		wr(1'b0, mdf_pkg::OFS_STATUS, {6'h00, c});
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(1'b1, mdf_pkg::OFS_STATUS, v);
		chk(v, 8'h20);
		rd(1'b0, mdf_pkg::OFS_STATUS, v);
		chk(v, 8'h20);
		rd(1'b1, mdf_pkg::OFS_CTRL, v);
		chk(v, 8'h03);
		rd(1'b1, mdf_pkg::OFS_BAUD, v);
		chk(v, mdf_pkg::BAUD_RESET);
		rd(1'b0, mdf_pkg::OFS_BAUD, v);
		chk(v, mdf_pkg::BAUD_RESET);
		wr(1'b1, mdf_pkg::OFS_CTRL, 8'h07);
		set_st(2'b01, 2'b00);
		send(1'b0, 1'b1, 8'h5a);
		rx(1'b1, 1'b1, 1'b1, 8'h5a);
		send(1'b0, 1'b0, 8'ha5);
		rx(1'b1, 1'b0, 1'b0, 8'ha5);
		set_st(2'b00, 2'b00);
		send(1'b0, 1'b0, 8'h3c);
		rx(1'b1, 1'b1, 1'b0, 8'h3c);
		set_st(2'b01, 2'b00);
		send(1'b0, 1'b0, 8'h99);
		rx(1'b1, 1'b0, 1'b0, 8'h99);
		send(1'b1, 1'b0, 8'h66);
		rx(1'b0, 1'b1, 1'b0, 8'h66);
		set_st(2'b11, 2'b10);
		send(1'b0, 1'b1, 8'h81);
		rx(1'b1, 1'b1, 1'b1, 8'h81);
		send(1'b0, 1'b0, 8'h18);
		rx(1'b1, 1'b0, 1'b0, 8'h18);
		set_st(2'b01, 2'b00);
		cfg = 7'h17;
		wr(1'b1, mdf_pkg::OFS_CTRL, 8'h17);
		send(1'b0, 1'b1, 8'h0f);
		rx(1'b1, 1'b1, 1'b1, 8'h0f);
		cfg = 7'h0b;
		wr(1'b1, mdf_pkg::OFS_CTRL, 8'h0b);
		send(1'b0, 1'b0, 8'h42);
		rx(1'b1, 1'b0, 1'b0, 8'h42);
		send(1'b0, 1'b1, 8'h24);
		rx(1'b1, 1'b1, 1'b1, 8'h24);
		end_of_test();
	end
endmodule

// ==== include/mdf_link_if.sv ====
/*
 Serial link between the control end and one device end.
 Assumes the testbench joins several device ends by wiring their reply
 lines together itself.
*/
`timescale 1ns/10ps
interface mdf_link_if;
	logic m2s_line;
	logic s2m_line;
	modport dev (input m2s_line, output s2m_line);
	modport ctrl (output m2s_line, input s2m_line);
endinterface

// ==== include/mdf_pkg.sv ====
/*
 Constants, types and helpers shared by both ends of a multi-drop serial
 link: a device end that filters frames by address marking and a control
 end that sends marked frames. Assumes one 200 MHz clock for both ends.
*/
// Functional notes
// - Filter on: unmarked frames never reach buffer.
// - Transmitter ignores the filter enable entirely.
// - Five to eight bits: first stop marks.
// - Nine bits: ninth data bit marks.
// - Mark one is address, zero is data.
// - Accepted address frame buffered, flags as normal.
// - Control end uses nine-bit size, code 7.
// - Ninth transmit bit: one address, zero data.
// - Device ends also use nine-bit size then.
// - Software compares address, clears filter if selected.
// - Unfiltered end takes data until next address.
// - After last data, software re-enables the filter.
// - Receiver and transmitter share one size setting.
// - Short sizes need two stop bits transmitted.
// - No read-modify-write on filter enable bit.
// - Sixteen samples per bit, eight double speed.
// - First vote sample 8, or 4 double.
// - Middle vote sample 9, or 5 double.
// - Data plus parity spans 5 to 10.
// - Far rate within receiver acceptance window.
// - Each end takes half the rate error.
// - Majority of three centre samples decides bit.
// - Double speed halves divider from 16 to 8.
package mdf_pkg;
	// ---------------------------------------------------------------
	// Register map of the software port
	// ---------------------------------------------------------------
	localparam logic [1:0] OFS_DATA   = 2'h0;
	localparam logic [1:0] OFS_STATUS = 2'h1;
	localparam logic [1:0] OFS_CTRL   = 2'h2;
	localparam logic [1:0] OFS_BAUD   = 2'h3;
	localparam int B_RXC   = 7;
	localparam int B_TXC   = 6;
	localparam int B_TXE   = 5;
	localparam int B_FE    = 4;
	localparam int B_OVR   = 3;
	localparam int B_PE    = 2;
	localparam int B_DBL   = 1;
	localparam int B_FILT  = 0;
	localparam int B_CS    = 0;
	localparam int B_TWO   = 3;
	localparam int B_PEN   = 4;
	localparam int B_PODD  = 5;
	localparam int B_RX9   = 6;
	localparam int B_TX9   = 7;
	localparam logic [2:0] CS_RESET  = 3'h3;
	localparam logic [2:0] CS_9BIT   = 3'h7;
	localparam logic [7:0] BAUD_RESET = 8'h00;
	// ---------------------------------------------------------------
	// Sampling figures
	// ---------------------------------------------------------------
	localparam logic [4:0] SPB_NORMAL   = 5'h10;
	localparam logic [4:0] SPB_DOUBLE   = 5'h08;
	localparam logic [4:0] VOTE1_NORMAL = 5'h08;
	localparam logic [4:0] VOTE1_DOUBLE = 5'h04;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_BITS  = 2'b10
	} mdf_rx_state_type;

	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_SEND = 1'b1
	} mdf_tx_state_type;

	function automatic logic [3:0] mdf_data_bits(input logic [2:0] cs);
		if (cs == CS_9BIT)
			return 4'h9;
		if (cs[2])
			return 4'h8;
		return {2'h0, cs[1:0]} + 4'h5;
	endfunction

	function automatic logic [8:0] mdf_mask(input logic [3:0] nd);
		return 9'h1ff >> (4'h9 - nd);
	endfunction

	function automatic logic [4:0] mdf_spb(input logic dbl);
		return dbl ? SPB_DOUBLE : SPB_NORMAL;
	endfunction

	function automatic logic [4:0] mdf_vote_first(input logic dbl);
		return dbl ? VOTE1_DOUBLE : VOTE1_NORMAL;
	endfunction

	function automatic logic mdf_majority(input logic [2:0] v);
		return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
	endfunction

	// Frame word sent least bit first: start, data, parity, stop ones.
	function automatic logic [12:0] mdf_tx_frame(input logic [8:0] d,
		input logic [3:0] nd, input logic pen, input logic podd);
		logic [12:0] f;
		f = '1;
		f[0] = 1'b0;
		for (int i = 0; i < 9; i++) begin
			if (i < nd)
				f[i + 1] = d[i];
		end
		if (pen)
			f[nd + 4'h1] = ^(d & mdf_mask(nd)) ^ podd;
		return f;
	endfunction
endpackage

// ==== rtl/mdf_control.sv ====
/*
 Control end: sends address-marked and data frames and receives replies
 without any filtering.
 Assumes the reply line is asynchronous to clk and idles high.
*/
`timescale 1ns/10ps
module mdf_control (
	input  wire logic       clk,
	input  wire logic       rst,
	mdf_link_if.ctrl        link,
	input  wire logic [1:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata
);
	typedef struct packed {
		logic                      s1;
		logic                      s2;
		logic [7:0]                bcnt;
		mdf_pkg::mdf_rx_state_type rstate;
		logic [4:0]                rsmp;
		logic [3:0]                ridx;
		logic [1:0]                rv;
		logic [9:0]                rbits;
		logic [8:0]                rbuf;
		logic                      rfull;
		logic                      fe;
		mdf_pkg::mdf_tx_state_type tstate;
		logic [4:0]                tsmp;
		logic [3:0]                tleft;
		logic [12:0]               tframe;
		logic [8:0]                tbuf;
		logic                      tfull;
		logic                      txc;
		logic                      txd;
		logic                      dbl;
		logic [2:0]                cs;
		logic                      two;
		logic                      pen;
		logic                      podd;
		logic                      tx9;
		logic [7:0]                baud;
		logic [7:0]                rdata;
	} mdf_ctl_state_type;

	mdf_ctl_state_type state_reg;
	mdf_ctl_state_type state_next;
	logic              tick;
	logic [3:0]        nd;
	logic [3:0]        nstop;
	logic [4:0]        spb;
	logic [4:0]        vf;
	logic              vote;

	assign rdata          = state_reg.rdata;
	assign link.m2s_line  = state_reg.txd;
	assign tick  = state_reg.bcnt == 8'h00;
	assign nd    = mdf_pkg::mdf_data_bits(state_reg.cs);
	assign nstop = nd + {3'h0, state_reg.pen};
	assign spb   = mdf_pkg::mdf_spb(state_reg.dbl);
	assign vf    = mdf_pkg::mdf_vote_first(state_reg.dbl);
	assign vote  = mdf_pkg::mdf_majority({state_reg.rv, state_reg.s2});

	always_comb begin
		state_next = state_reg;
		state_next.s1 = link.s2m_line;
		state_next.s2 = state_reg.s1;
		state_next.rdata = 8'h00;
		state_next.bcnt = tick ? state_reg.baud : state_reg.bcnt - 8'h01;

		if (wr) begin
			unique case (addr)
				mdf_pkg::OFS_DATA: begin
					// The marking bit is taken from the control word that
					// software set before this write.
					if (!state_reg.tfull) begin
						state_next.tbuf = {state_reg.tx9, wdata};
						state_next.tfull = 1'b1;
					end
				end
				mdf_pkg::OFS_STATUS: begin
					state_next.dbl = wdata[mdf_pkg::B_DBL];
					if (wdata[mdf_pkg::B_TXC])
						state_next.txc = 1'b0;
				end
				mdf_pkg::OFS_CTRL: begin
					state_next.cs = wdata[mdf_pkg::B_CS +: 3];
					state_next.two = wdata[mdf_pkg::B_TWO];
					state_next.pen = wdata[mdf_pkg::B_PEN];
					state_next.podd = wdata[mdf_pkg::B_PODD];
					state_next.tx9 = wdata[mdf_pkg::B_TX9];
				end
				mdf_pkg::OFS_BAUD: state_next.baud = wdata;
			endcase
		end

		if (rd) begin
			unique case (addr)
				mdf_pkg::OFS_DATA: begin
					state_next.rdata = state_reg.rbuf[7:0];
					state_next.rfull = 1'b0;
					state_next.fe = 1'b0;
				end
				mdf_pkg::OFS_STATUS: begin
					state_next.rdata[mdf_pkg::B_RXC] = state_reg.rfull;
					state_next.rdata[mdf_pkg::B_TXC] = state_reg.txc;
					state_next.rdata[mdf_pkg::B_TXE] = !state_reg.tfull;
					state_next.rdata[mdf_pkg::B_FE] = state_reg.fe;
					state_next.rdata[mdf_pkg::B_DBL] = state_reg.dbl;
				end
				mdf_pkg::OFS_CTRL: begin
					state_next.rdata[mdf_pkg::B_CS +: 3] = state_reg.cs;
					state_next.rdata[mdf_pkg::B_TWO] = state_reg.two;
					state_next.rdata[mdf_pkg::B_PEN] = state_reg.pen;
					state_next.rdata[mdf_pkg::B_PODD] = state_reg.podd;
					state_next.rdata[mdf_pkg::B_RX9] = state_reg.rbuf[8];
					state_next.rdata[mdf_pkg::B_TX9] = state_reg.tx9;
				end
				mdf_pkg::OFS_BAUD: state_next.rdata = state_reg.baud;
			endcase
		end

		// ---------------------------------------------------------------
		// Reply receiver
		// ---------------------------------------------------------------
		if (tick) begin
			unique case (state_reg.rstate)
				mdf_pkg::RX_IDLE: begin
					if (!state_reg.s2) begin
						state_next.rstate = mdf_pkg::RX_START;
						// The tick that saw the line low was sample one.
						state_next.rsmp = 5'h02;
					end
				end
				mdf_pkg::RX_START, mdf_pkg::RX_BITS: begin
					state_next.rsmp = (state_reg.rsmp == spb)
						? 5'h01 : state_reg.rsmp + 5'h01;
					if (state_reg.rsmp == vf)
						state_next.rv[1] = state_reg.s2;
					if (state_reg.rsmp == vf + 5'h01)
						state_next.rv[0] = state_reg.s2;
					if (state_reg.rstate == mdf_pkg::RX_START) begin
						if (state_reg.rsmp == spb) begin
							state_next.rstate = mdf_pkg::RX_BITS;
							state_next.ridx = 4'h0;
						end
						if (state_reg.rsmp == vf + 5'h02 && vote)
							state_next.rstate = mdf_pkg::RX_IDLE;
					end else if (state_reg.rsmp == vf + 5'h02) begin
						if (state_reg.ridx != nstop) begin
							state_next.rbits[state_reg.ridx] = vote;
							state_next.ridx = state_reg.ridx + 4'h1;
						end else begin
							// An unread reply is overwritten by the next one.
							state_next.rstate = mdf_pkg::RX_IDLE;
							state_next.rbuf = state_reg.rbits[8:0]
								& mdf_pkg::mdf_mask(nd);
							state_next.rfull = 1'b1;
							state_next.fe = !vote;
						end
					end
				end
				default: state_next.rstate = mdf_pkg::RX_IDLE;
			endcase
		end

		// ---------------------------------------------------------------
		// Transmitter
		// ---------------------------------------------------------------
		unique case (state_reg.tstate)
			mdf_pkg::TX_IDLE: begin
				if (tick && state_reg.tfull) begin
					state_next.tframe = mdf_pkg::mdf_tx_frame(state_reg.tbuf,
						nd, state_reg.pen, state_reg.podd);
					// Short sizes send the marking bit as the first stop bit.
					if (state_reg.cs != mdf_pkg::CS_9BIT)
						state_next.tframe[nstop + 4'h1] = state_reg.tbuf[8];
					// Two stop bits keep a full stop after the marking bit.
					state_next.tleft = nstop + 4'h2 + {3'h0, state_reg.two};
					state_next.tfull = 1'b0;
					state_next.tsmp = 5'h01;
					state_next.tstate = mdf_pkg::TX_SEND;
				end
			end
			mdf_pkg::TX_SEND: begin
				if (tick) begin
					if (state_reg.tsmp == spb) begin
						state_next.tsmp = 5'h01;
						state_next.tframe = {1'b1, state_reg.tframe[12:1]};
						state_next.tleft = state_reg.tleft - 4'h1;
						if (state_reg.tleft == 4'h1) begin
							state_next.tstate = mdf_pkg::TX_IDLE;
							if (!state_next.tfull)
								state_next.txc = 1'b1;
						end
					end else begin
						state_next.tsmp = state_reg.tsmp + 5'h01;
					end
				end
			end
		endcase
		state_next.txd = (state_next.tstate == mdf_pkg::TX_SEND)
			? state_next.tframe[0] : 1'b1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.s1 <= 1'b1;
			state_reg.s2 <= 1'b1;
			state_reg.txd <= 1'b1;
			state_reg.tframe <= '1;
			state_reg.cs <= mdf_pkg::CS_RESET;
			state_reg.baud <= mdf_pkg::BAUD_RESET;
		end else begin
			state_reg <= state_next;
		end
	end
endmodule

// ==== rtl/mdf_device.sv ====
/*
 Device end: receiver with address-marked frame filter, one-entry
 receive buffer, transmitter and software register port.
 Assumes the line is asynchronous to clk and idles high.
*/
`timescale 1ns/10ps
module mdf_device (
	input  wire logic       clk,
	input  wire logic       rst,
	mdf_link_if.dev         link,
	input  wire logic [1:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata
);
	typedef struct packed {
		logic                      s1;
		logic                      s2;
		logic [7:0]                bcnt;
		mdf_pkg::mdf_rx_state_type rstate;
		logic [4:0]                rsmp;
		logic [3:0]                ridx;
		logic [1:0]                rv;
		logic [9:0]                rbits;
		logic [8:0]                rbuf;
		logic                      rfull;
		logic                      fe;
		logic                      pe;
		logic                      ovr;
		mdf_pkg::mdf_tx_state_type tstate;
		logic [4:0]                tsmp;
		logic [3:0]                tleft;
		logic [12:0]               tframe;
		logic [8:0]                tbuf;
		logic                      tfull;
		logic                      txc;
		logic                      txd;
		logic                      filt;
		logic                      dbl;
		logic [2:0]                cs;
		logic                      two;
		logic                      pen;
		logic                      podd;
		logic                      tx9;
		logic [7:0]                baud;
		logic [7:0]                rdata;
	} mdf_dev_state_type;

	mdf_dev_state_type state_reg;
	mdf_dev_state_type state_next;
	logic              tick;
	logic [3:0]        nd;
	logic [3:0]        nstop;
	logic [4:0]        spb;
	logic [4:0]        vf;
	logic              vote;
	logic [8:0]        rx_word;
	logic              ftype;
	logic              perr;

	assign rdata         = state_reg.rdata;
	assign link.s2m_line = state_reg.txd;

	assign tick  = state_reg.bcnt == 8'h00;
	assign nd    = mdf_pkg::mdf_data_bits(state_reg.cs);
	assign nstop = nd + {3'h0, state_reg.pen};
	assign spb   = mdf_pkg::mdf_spb(state_reg.dbl);
	assign vf    = mdf_pkg::mdf_vote_first(state_reg.dbl);
	assign vote  = mdf_pkg::mdf_majority({state_reg.rv, state_reg.s2});
	assign rx_word = state_reg.rbits[8:0] & mdf_pkg::mdf_mask(nd);
	assign perr  = state_reg.pen
		& ((^rx_word ^ state_reg.podd) != state_reg.rbits[nd]);

	// -------------------------------------------------------------------
	// Frame marking
	// -------------------------------------------------------------------
	// A nine-bit size marks by the ninth data bit, shorter sizes by the
	// first stop bit; a one marks an address frame.
	assign ftype = (state_reg.cs == mdf_pkg::CS_9BIT)
		? state_reg.rbits[8]
		: vote;

	// -------------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.s1 = link.m2s_line;
		state_next.s2 = state_reg.s1;
		state_next.rdata = 8'h00;
		// Sample tick every baud+1 clocks; each end budgets its own
		// clock error against the receiver's acceptance window.
		state_next.bcnt = tick ? state_reg.baud : state_reg.bcnt - 8'h01;

		if (wr) begin
			unique case (addr)
				mdf_pkg::OFS_DATA: begin
					// Writes while the buffer holds a character are dropped.
					if (!state_reg.tfull) begin
						state_next.tbuf = {state_reg.tx9, wdata};
						state_next.tfull = 1'b1;
					end
				end
				mdf_pkg::OFS_STATUS: begin
					// The filter enable shares this word with the sticky
					// transmit flag, so software writes it whole.
					state_next.filt = wdata[mdf_pkg::B_FILT];
					state_next.dbl = wdata[mdf_pkg::B_DBL];
					if (wdata[mdf_pkg::B_TXC])
						state_next.txc = 1'b0;
				end
				mdf_pkg::OFS_CTRL: begin
					state_next.cs = wdata[mdf_pkg::B_CS +: 3];
					state_next.two = wdata[mdf_pkg::B_TWO];
					state_next.pen = wdata[mdf_pkg::B_PEN];
					state_next.podd = wdata[mdf_pkg::B_PODD];
					state_next.tx9 = wdata[mdf_pkg::B_TX9];
				end
				mdf_pkg::OFS_BAUD: state_next.baud = wdata;
			endcase
		end

		if (rd) begin
			unique case (addr)
				mdf_pkg::OFS_DATA: begin
					state_next.rdata = state_reg.rbuf[7:0];
					state_next.rfull = 1'b0;
					state_next.fe = 1'b0;
					state_next.pe = 1'b0;
					state_next.ovr = 1'b0;
				end
				mdf_pkg::OFS_STATUS: begin
					state_next.rdata[mdf_pkg::B_RXC] = state_reg.rfull;
					state_next.rdata[mdf_pkg::B_TXC] = state_reg.txc;
					state_next.rdata[mdf_pkg::B_TXE] = !state_reg.tfull;
					state_next.rdata[mdf_pkg::B_FE] = state_reg.fe;
					state_next.rdata[mdf_pkg::B_OVR] = state_reg.ovr;
					state_next.rdata[mdf_pkg::B_PE] = state_reg.pe;
					state_next.rdata[mdf_pkg::B_DBL] = state_reg.dbl;
					state_next.rdata[mdf_pkg::B_FILT] = state_reg.filt;
				end
				mdf_pkg::OFS_CTRL: begin
					state_next.rdata[mdf_pkg::B_CS +: 3] = state_reg.cs;
					state_next.rdata[mdf_pkg::B_TWO] = state_reg.two;
					state_next.rdata[mdf_pkg::B_PEN] = state_reg.pen;
					state_next.rdata[mdf_pkg::B_PODD] = state_reg.podd;
					state_next.rdata[mdf_pkg::B_RX9] = state_reg.rbuf[8];
					state_next.rdata[mdf_pkg::B_TX9] = state_reg.tx9;
				end
				mdf_pkg::OFS_BAUD: state_next.rdata = state_reg.baud;
			endcase
		end

		// ---------------------------------------------------------------
		// Receiver
		// ---------------------------------------------------------------
		if (tick) begin
			unique case (state_reg.rstate)
				mdf_pkg::RX_IDLE: begin
					if (!state_reg.s2) begin
						state_next.rstate = mdf_pkg::RX_START;
						// The tick that saw the line low was sample one.
						state_next.rsmp = 5'h02;
					end
				end
				mdf_pkg::RX_START, mdf_pkg::RX_BITS: begin
					state_next.rsmp = (state_reg.rsmp == spb)
						? 5'h01 : state_reg.rsmp + 5'h01;
					if (state_reg.rsmp == vf)
						state_next.rv[1] = state_reg.s2;
					if (state_reg.rsmp == vf + 5'h01)
						state_next.rv[0] = state_reg.s2;
					if (state_reg.rstate == mdf_pkg::RX_START) begin
						if (state_reg.rsmp == spb) begin
							state_next.rstate = mdf_pkg::RX_BITS;
							state_next.ridx = 4'h0;
						end
						// A high majority in the start bit is a spike.
						if (state_reg.rsmp == vf + 5'h02 && vote)
							state_next.rstate = mdf_pkg::RX_IDLE;
					end else if (state_reg.rsmp == vf + 5'h02) begin
						if (state_reg.ridx != nstop) begin
							state_next.rbits[state_reg.ridx] = vote;
							state_next.ridx = state_reg.ridx + 4'h1;
						end else begin
							// Stop bit decided: the line may start a new
							// frame right after the last vote sample.
							state_next.rstate = mdf_pkg::RX_IDLE;
							// Unmarked frames vanish while filtering and
							// leave every receive flag as it was.
							if (!state_reg.filt || ftype) begin
								if (state_next.rfull) begin
									state_next.ovr = 1'b1;
								end else begin
									state_next.rbuf = rx_word;
									state_next.rfull = 1'b1;
									state_next.fe = !vote;
									state_next.pe = perr;
								end
							end
						end
					end
				end
				default: state_next.rstate = mdf_pkg::RX_IDLE;
			endcase
		end

		// ---------------------------------------------------------------
		// Transmitter
		// ---------------------------------------------------------------
		// The filter enable has no path into this section.
		unique case (state_reg.tstate)
			mdf_pkg::TX_IDLE: begin
				if (tick && state_reg.tfull) begin
					state_next.tframe = mdf_pkg::mdf_tx_frame(state_reg.tbuf,
						nd, state_reg.pen, state_reg.podd);
					state_next.tleft = nstop + 4'h2 + {3'h0, state_reg.two};
					state_next.tfull = 1'b0;
					state_next.tsmp = 5'h01;
					state_next.tstate = mdf_pkg::TX_SEND;
				end
			end
			mdf_pkg::TX_SEND: begin
				if (tick) begin
					if (state_reg.tsmp == spb) begin
						state_next.tsmp = 5'h01;
						state_next.tframe = {1'b1, state_reg.tframe[12:1]};
						state_next.tleft = state_reg.tleft - 4'h1;
						if (state_reg.tleft == 4'h1) begin
							state_next.tstate = mdf_pkg::TX_IDLE;
							if (!state_next.tfull)
								state_next.txc = 1'b1;
						end
					end else begin
						state_next.tsmp = state_reg.tsmp + 5'h01;
					end
				end
			end
		endcase
		state_next.txd = (state_next.tstate == mdf_pkg::TX_SEND)
			? state_next.tframe[0] : 1'b1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.s1 <= 1'b1;
			state_reg.s2 <= 1'b1;
			state_reg.txd <= 1'b1;
			state_reg.tframe <= '1;
			state_reg.cs <= mdf_pkg::CS_RESET;
			state_reg.baud <= mdf_pkg::BAUD_RESET;
		end else begin
			state_reg <= state_next;
		end
	end
endmodule
